/* dv/cgo_regs_checker.sv */
// assertion checker for the gain and offset register bank
`timescale 1ns/1ps
`default_nettype none
module cgo_regs_checker
    import cgo_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [CGO_ADDR_W-1:0] reg_addr,
    input wire logic [CGO_REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [CGO_REG_W-1:0] reg_rdata,
    // sample path
    input wire logic in_valid,
    input wire logic [3*CGO_DATA_W-1:0] in_data,
    input wire logic out_valid,
    input wire logic [3*CGO_DATA_W-1:0] out_data,
    input wire logic [2:0] offset_copy_mismatch
);
    // shadow of the two enables
    logic [1:0] en_r;
    always_ff @(posedge clk) begin
        if (reset) en_r <= 2'h0;
        else if (reg_wr && reg_addr == CGO_CTRL) en_r <= {reg_wdata[12], reg_wdata[8]};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // register port and sample path relations
    a_reset_clears_all: assert property (disable iff (1'b0) reset |=> reg_rdata == 16'h0
        && !out_valid && out_data == 42'h0 && offset_copy_mismatch == 3'h0) else $error("reset");
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0) else $error("idle");
    a_unmapped_reads_zero: assert property (reg_rd && !(reg_addr inside {8'h03, [8'h19:8'h1e]})
        |=> reg_rdata == 16'h0) else $error("unmapped read");
    a_copy_upper_zero: assert property (reg_rd && reg_addr inside {8'h1a, 8'h1c, 8'h1e}
        |=> reg_rdata[15:10] == 6'h0) else $error("copy reserved");
    a_gain_bit10_zero: assert property (reg_rd && reg_addr inside {8'h19, 8'h1b, 8'h1d}
        |=> !reg_rdata[10]) else $error("bit 10 set");
    a_ch7_write_read: assert property ((reg_wr && reg_addr == 8'h1d) ##1 (reg_rd &&
        reg_addr == 8'h1d) |=> reg_rdata == ($past(reg_wdata, 2) & 16'hfbff)) else $error("ch7");
    a_valid_one_cycle: assert property (1'b1 |=> out_valid == $past(in_valid)) else $error("valid");
    a_passthru_disabled: assert property (in_valid && en_r == 2'h0
        |=> out_data == $past(in_data)) else $error("passthrough");
    a_flag_after_write: assert property ($changed(offset_copy_mismatch)
        |-> $past(reg_wr) || $past(reg_wr, 2)) else $error("mismatch flag");
endmodule : cgo_regs_checker
bind cgo_regs cgo_regs_checker u_chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .in_valid, .in_data, .out_valid, .out_data, .offset_copy_mismatch);
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the gain and offset register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cgo_pkg::*;
;
    // stimulus and observed signals
    logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata;
    logic [41:0] in_data = 42'h0, out_data;
    logic out_valid;
    logic [2:0] offset_copy_mismatch;
    int fail_count = 0, total_checks = 0, cyc = 0;
    cgo_regs DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid,
        .in_data, .out_valid, .out_data, .offset_copy_mismatch);
    // clock and hang guard
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [42:0] got, input logic [42:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // primary register and its offset copy, kept equal
    task automatic wgo(input logic [7:0] a, input logic [15:0] d);
        wr(a, d);
        wr(8'(a + 1), d & 16'h03ff);
    endtask : wgo
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk({27'h0, reg_rdata}, {27'h0, exp});
    endtask : rdc
    function automatic logic [41:0] pk(input int a, input int b, input int c);
        return {c[13:0], b[13:0], a[13:0]};
    endfunction : pk
    task automatic smp(input logic [41:0] d, input logic [41:0] exp);
        @(posedge clk);
        in_data <= d;
        in_valid <= 1'b1;
        @(posedge clk);
        in_valid <= 1'b0;
        #1 chk({out_valid, out_data}, {1'b1, exp});
    endtask : smp
    // scenarios
    task automatic t_reset;
        rdc(8'h03, 16'h0);
        for (int a = 8'h19; a <= 8'h1e; a++) rdc(8'(a), 16'h0);
    endtask : t_reset
    task automatic t_map;
        for (int a = 8'h19; a <= 8'h1e; a++) begin
            wr(8'(a), a[0] ? 16'hfbff : 16'h03ff);
            rdc(8'(a), a[0] ? 16'hfbff : 16'h03ff);
        end
        wr(8'h1f, 16'hffff);
        rdc(8'h1f, 16'h0);
    endtask : t_map
    task automatic t_copy;
        for (int i = 0; i < 3; i++) begin
            wr(8'(8'h19 + 2 * i), 16'h0007);
            wr(8'(8'h1a + 2 * i), 16'h0008);
            repeat (2) @(posedge clk);
            #1 chk({40'h0, offset_copy_mismatch}, 43'(1 << i));
            wr(8'(8'h1a + 2 * i), 16'h0007);
            repeat (2) @(posedge clk);
            #1 chk({40'h0, offset_copy_mismatch}, 43'h0);
        end
    endtask : t_copy
    task automatic t_b2b;
        @(posedge clk);
        reg_addr <= 8'h1d;
        reg_wdata <= 16'h0805;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk({27'h0, reg_rdata}, 43'h0805);
        @(posedge clk);
        #1 chk({27'h0, reg_rdata}, 43'h0);
        wr(8'h1e, 16'h0005);
    endtask : t_b2b
    task automatic t_offset;
        wgo(8'h19, 16'h5005);
        wgo(8'h1b, 16'h53fd);
        wgo(8'h1d, 16'h5200);
        smp(pk(100, 100, 100), pk(100, 100, 100));
        wr(8'h03, 16'h0100);
        smp(pk(100, 100, 100), pk(105, 97, -412));
    endtask : t_offset
    task automatic t_gain;
        wgo(8'h19, 16'h0000);
        wgo(8'h1b, 16'h2800);
        wgo(8'h1d, 16'hf800);
        wr(8'h03, 16'h1000);
        smp(pk(1024, 1024, 8000), pk(1024, 1149, 8191));
        smp(pk(-100, -1024, -8000), pk(-100, -1149, -8192));
        wgo(8'h19, 16'h2818);
        wr(8'h03, 16'h1100);
        smp(pk(1000, 1024, 0), pk(1149, 1149, 0));
    endtask : t_gain
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_map();
        t_copy();
        t_b2b();
        t_offset();
        t_gain();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire

/* logic/cgo_chan_corr.sv */
// one channel of gain and offset correction on sample data
`timescale 1ns/1ps
`default_nettype none
module cgo_chan_corr
    import cgo_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // settings
    input wire logic gain_correction_enable,
    input wire logic offset_correction_enable,
    input wire logic [CGO_GAIN_W-1:0] gain,
    input wire logic [CGO_OFS_W-1:0] offset,
    // sample path
    input wire logic in_valid,
    input wire logic signed [CGO_DATA_W-1:0] in_data,
    output logic out_valid,
    output logic signed [CGO_DATA_W-1:0] out_data
);

    // linear factor 10^(N*0.2/20) in q2.12, entry N
    function automatic logic [CGO_MULT_W-1:0] cgo_gain_lin(input logic [CGO_GAIN_W-1:0] n);
        logic [CGO_MULT_W-1:0] t [0:31];
        t = '{14'h1000, 14'h105f, 14'h10c1, 14'h1125, 14'h118b, 14'h11f4, 14'h125f,
              14'h12cc, 14'h133c, 14'h13af, 14'h1425, 14'h149d, 14'h1518, 14'h1595,
              14'h1616, 14'h169a, 14'h1721, 14'h17aa, 14'h1838, 14'h18c8, 14'h195c,
              14'h19f3, 14'h1a8e, 14'h1b2c, 14'h1bce, 14'h1c74, 14'h1d1d, 14'h1dcb,
              14'h1e7d, 14'h1f33, 14'h1fed, 14'h20ab};
        return t[n];
    endfunction : cgo_gain_lin

    // saturate a wide value to the sample width
    function automatic logic signed [CGO_DATA_W-1:0] cgo_sat(input logic signed [31:0] v);
        if (v > 32'sd8191) begin
            return 14'sh1fff;
        end else if (v < -32'sd8192) begin
            return -14'sh2000;
        end
        return v[CGO_DATA_W-1:0];
    endfunction : cgo_sat

    wire logic signed [31:0] ofs_ext = 32'(signed'(offset)); // [R02]
    wire logic signed [31:0] with_ofs = offset_correction_enable ?
        32'(in_data) + ofs_ext : 32'(in_data); // [R01] [R12]
    wire logic [CGO_MULT_W-1:0] mult = gain_correction_enable ?
        cgo_gain_lin(gain) : 14'h1000; // [R03] [R04] [R12]
    wire logic signed [31:0] prod = (with_ofs * $signed({18'h0, mult})) >>> CGO_GAIN_FRAC;

    // output sample register
    always_ff @(posedge clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= in_valid;
            out_data <= cgo_sat(prod);
        end
    end

endmodule : cgo_chan_corr
`default_nettype wire

/* logic/cgo_pkg.sv */
// constants of the channel gain and offset correction register bank
//
// Summary of operation
// (R01) offset applies to channel data only while offset_correction_enable is set
// (R02) each 10-bit offset field is a signed two's-complement number
// (R03) gain comes from bits 15-11 of the gain/offset register while enabled
// (R04) gain field value N gives a digital gain of N times 0.2 dB
// (R05) software writes the same channel-5 offset into registers 0x19 and 0x1a
// (R06) software writes the same channel-6 offset into registers 0x1b and 0x1c
// (R07) software writes the same channel-7 offset into registers 0x1d and 0x1e
// (R08) registers decode at 0x19 to 0x1e; channel 7 gain/offset at 0x1d
// (R09) every field resets to zero: zero gain and zero offset
// (R10) channel 5 gain lives in bits 15-11 of register 0x19, same enable and scale
// (R11) software writes zero to reserved bits
// (R12) with enables clear, channel data passes unchanged
package cgo_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CGO_CH5_GAIN_AND_OFFSET = 8'h19;
    localparam logic [7:0] CGO_CH5_OFFSET_COPY = 8'h1a;
    localparam logic [7:0] CGO_CH6_GAIN_AND_OFFSET = 8'h1b;
    localparam logic [7:0] CGO_CH6_OFFSET_COPY = 8'h1c;
    localparam logic [7:0] CGO_CH7_GAIN_AND_OFFSET = 8'h1d;
    localparam logic [7:0] CGO_CH7_OFFSET_COPY = 8'h1e;
    localparam logic [7:0] CGO_CTRL = 8'h03;

    // ------------------------------------------------------------
    // fields and widths
    // ------------------------------------------------------------
    localparam int CGO_ADDR_W = 8;
    localparam int CGO_REG_W = 16;
    localparam int CGO_DATA_W = 14;
    localparam int CGO_GAIN_LSB = 11;
    localparam int CGO_GAIN_W = 5;
    localparam int CGO_OFS_W = 10;
    localparam int CGO_CTRL_GAIN_EN_BIT = 12;
    localparam int CGO_CTRL_OFS_EN_BIT = 8;
    localparam logic [15:0] CGO_GO_MASK = 16'hfbff;
    localparam logic [15:0] CGO_COPY_MASK = 16'h03ff;
    localparam logic [15:0] CGO_CTRL_MASK = 16'h1100;
    localparam logic [15:0] CGO_RESET_VAL = 16'h0000;

    // ------------------------------------------------------------
    // gain scaling: 0.2 dB per step, gain table in q2.12
    // ------------------------------------------------------------
    localparam int CGO_GAIN_FRAC = 12;
    localparam int CGO_MULT_W = 14;

endpackage : cgo_pkg

/* logic/cgo_regs.sv */
// gain and offset register bank for channels 5 to 7 with correction datapath
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cgo_regs
    import cgo_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [CGO_ADDR_W-1:0] reg_addr,
    input wire logic [CGO_REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [CGO_REG_W-1:0] reg_rdata,
    // sample inputs, channels 5..7
    input wire logic in_valid,
    input wire logic [3*CGO_DATA_W-1:0] in_data,
    // corrected samples, channels 5..7
    output logic out_valid,
    output logic [3*CGO_DATA_W-1:0] out_data,
    // copy mismatch flags, channels 5..7
    output logic [2:0] offset_copy_mismatch
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [CGO_REG_W-1:0] go_r [0:2];
    logic [CGO_REG_W-1:0] copy_r [0:2];
    logic [CGO_REG_W-1:0] ctrl_r;
    logic [2:0] vld;

    // address decode
    wire logic hit_ctrl = reg_addr == CGO_CTRL;
    wire logic [2:0] hit_go = {reg_addr == CGO_CH7_GAIN_AND_OFFSET,
                               reg_addr == CGO_CH6_GAIN_AND_OFFSET,
                               reg_addr == CGO_CH5_GAIN_AND_OFFSET}; // [R08] [R10]
    wire logic [2:0] hit_copy = {reg_addr == CGO_CH7_OFFSET_COPY,
                                 reg_addr == CGO_CH6_OFFSET_COPY,
                                 reg_addr == CGO_CH5_OFFSET_COPY}; // [R08]

    // enables
    wire logic gain_correction_enable = ctrl_r[CGO_CTRL_GAIN_EN_BIT];
    wire logic offset_correction_enable = ctrl_r[CGO_CTRL_OFS_EN_BIT];

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= CGO_RESET_VAL; // [R09]
            for (int i = 0; i < 3; i++) begin
                go_r[i] <= CGO_RESET_VAL; // [R09]
                copy_r[i] <= CGO_RESET_VAL; // [R09]
            end
        end else if (reg_wr) begin
            if (hit_ctrl) begin
                ctrl_r <= reg_wdata & CGO_CTRL_MASK;
            end
            for (int i = 0; i < 3; i++) begin
                if (hit_go[i]) begin
                    go_r[i] <= reg_wdata & CGO_GO_MASK; // reserved bit 10 held zero [R11]
                end
                if (hit_copy[i]) begin
                    copy_r[i] <= reg_wdata & CGO_COPY_MASK; // [R11]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read path: data one cycle after the strobe, zero otherwise
    // ------------------------------------------------------------
    wire logic [CGO_REG_W-1:0] rd_mux =
        hit_ctrl ? ctrl_r :
        hit_go[0] ? go_r[0] : hit_go[1] ? go_r[1] : hit_go[2] ? go_r[2] :
        hit_copy[0] ? copy_r[0] : hit_copy[1] ? copy_r[1] :
        hit_copy[2] ? copy_r[2] : 16'h0000;

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // copy mismatch status: primary offset differs from its copy
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            offset_copy_mismatch <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                offset_copy_mismatch[i] <= go_r[i][CGO_OFS_W-1:0] != copy_r[i][CGO_OFS_W-1:0]; // [R05] [R06] [R07]
            end
        end
    end

    // ------------------------------------------------------------
    // per-channel correction
    // ------------------------------------------------------------
    for (genvar c = 0; c < 3; c++) begin : g_chan
        cgo_chan_corr u_corr (
            .clk(clk),
            .reset(reset),
            .gain_correction_enable(gain_correction_enable),
            .offset_correction_enable(offset_correction_enable),
            .gain(go_r[c][CGO_GAIN_LSB +: CGO_GAIN_W]), // [R03] [R10]
            .offset(go_r[c][CGO_OFS_W-1:0]), // [R01]
            .in_valid(in_valid),
            .in_data(in_data[c*CGO_DATA_W +: CGO_DATA_W]),
            .out_valid(vld[c]),
            .out_data(out_data[c*CGO_DATA_W +: CGO_DATA_W])
        );
    end

    assign out_valid = vld[0];

endmodule : cgo_regs
`default_nettype wire
